// ===== hdl/timer_pkg.sv
`default_nettype none

package timer_pkg;

	// register byte addresses on the bus
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] ADDR_MAIN_SC = 8'h00;
	localparam logic [7:0] ADDR_COUNT   = 8'h04;
	localparam logic [7:0] ADDR_MOD_HI  = 8'h08;
	localparam logic [7:0] ADDR_MOD_LO  = 8'h0c;
	localparam logic [7:0] ADDR_CH_SC   = 8'h10;
	localparam logic [7:0] ADDR_CH_VAL  = 8'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// counter constants
	localparam logic [15:0] CNT_ZERO     = 16'h0000;
	localparam logic [15:0] CNT_ONE      = 16'h0001;
	localparam logic [15:0] CNT_FREE_TOP = 16'hffff;
	localparam logic [6:0]  PRESC_STEP   = 7'h01;

	// counter clock select codes
	localparam logic [1:0] CLK_OFF   = 2'h0;
	localparam logic [1:0] CLK_BUS   = 2'h1;
	localparam logic [1:0] CLK_FIXED = 2'h2;
	localparam logic [1:0] CLK_EXT   = 2'h3;

	// edge/level select codes
	localparam logic [1:0] ELS_GPIO   = 2'h0;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR  = 2'h2;
	localparam logic [1:0] ELS_SET    = 2'h3;
	localparam logic [1:0] MS_CAPTURE = 2'h0;
	localparam logic [1:0] MS_COMPARE = 2'h1;

	// main status/control layout, bit 7 down to bit 0
	typedef struct packed {
		logic       flag;
		logic       ie;
		logic       cpwm;
		logic [1:0] clk_sel;
		logic [2:0] ps;
	} main_ctl_t;

	// channel status/control layout, bits 1:0 reserved
	typedef struct packed {
		logic       flag;
		logic       ie;
		logic [1:0] ms;
		logic [1:0] els;
		logic [1:0] rsvd;
	} ch_ctl_t;

	typedef enum logic [1:0] {
		CH_CAPTURE = 2'b00,
		CH_COMPARE = 2'b01,
		CH_EPWM    = 2'b10,
		CH_CPWM    = 2'b11
	} ch_mode_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_t;

	typedef struct packed {
		main_ctl_t   sc;
		logic        ovf_armed;
		logic [15:0] cnt;
		logic        cnt_down;
		logic [6:0]  presc;
		logic [15:0] modulo;
		logic [15:0] mod_buf;
		logic        lat_hi;
		logic        lat_lo;
		ch_ctl_t     ch;
		logic        ch_armed;
		logic [15:0] ch_val;
		logic        pin_out;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} timer_state_t;

	localparam timer_state_t STATE_RESET = '0;
	localparam sync_t        SYNC_RESET  = '0;

endpackage : timer_pkg

`default_nettype wire

// ===== hdl/pin_edge_sync.sv
`default_nettype none

// two-flop synchroniser plus one stage for edge detection
module pin_edge_sync
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);

	timer_pkg::sync_t s;
	timer_pkg::sync_t next_s;

	// s1 feeds only s2; edges are judged from s2 and s3
	always_comb
	begin
		next_s    = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= timer_pkg::SYNC_RESET;
		else
			s <= next_s;
	end

	assign rise = s.s2 & ~s.s3;
	assign fall = ~s.s2 & s.s3;

endmodule : pin_edge_sync

`default_nettype wire

// ===== hdl/timer_modulo_channel_ctrl.sv
// What this block does
// - at modulo, restart at zero (center-aligned: count down), set overflow
// - half-written modulo suppresses overflow flag
// - modulo resets zero; zero means free-run
// - buffered modulo; clock off: transfer immediately
// - clock on: transfer stepping into old modulo
// - main control write resets modulo latches
// - debug mode freezes modulo latches, except a main control write resets them
// - debug mode writes modulo directly
// - capture edge sets channel flag
// - compare match sets channel flag
// - pwm at 0% or 100% never flags
// - channel interrupt when flag and enable
// - clear flag: read set, write zero
// - new event restarts clear sequence
// - edge select zero releases the pin
// - capture mode with rising/falling/both edges
// - compare toggles, clears or sets pin
// - edge-aligned pwm high- or low-true
// - center-aligned pwm high- or low-true
// - center-aligned counts up and down
// - clock select zero stops the counter
`default_nettype none

module timer_modulo_channel_ctrl
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        background_debug_mode,
	input  wire logic        ext_clk_pin,
	input  wire logic        ch_pin_in,
	output logic             ch_pin_out,
	output logic             ch_pin_oe_n,
	output logic             overflow_irq,
	output logic             channel_irq
);

	timer_pkg::timer_state_t s;
	timer_pkg::timer_state_t next_s;
	timer_pkg::main_ctl_t    wsc;
	timer_pkg::ch_ctl_t      wch;
	timer_pkg::ch_mode_t     mode;
	logic [15:0] top;
	logic        ext_rise;
	logic        ch_rise;
	logic        ch_fall;
	logic        src;
	logic        tick;
	logic        ovf;
	logic        step_to_top;
	logic        match;
	logic        extreme;
	logic        ch_event;
	logic        do_write;
	logic        sc_wr;
	logic        ch_wr;
	logic        ch_rd;

	// mask of prescaler bits that must all be ones for a tick
	function automatic logic [6:0] prescale_mask(input logic [2:0] ps);
		logic [7:0] m;
		m = (8'h01 << ps) - 8'h01;
		return m[6:0];
	endfunction : prescale_mask

	// center-aligned select overrides the per-channel mode bits
	function automatic timer_pkg::ch_mode_t channel_mode(input logic cpwm,
		input logic [1:0] ms);
		timer_pkg::ch_mode_t m;
		m = timer_pkg::CH_CAPTURE;
		if (cpwm)
			m = timer_pkg::CH_CPWM;
		else if (ms[1])
			m = timer_pkg::CH_EPWM;
		else if (ms == timer_pkg::MS_COMPARE)
			m = timer_pkg::CH_COMPARE;
		else
			m = timer_pkg::CH_CAPTURE;
		return m;
	endfunction : channel_mode

	pin_edge_sync u_ext_sync
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (ext_clk_pin),
		.rise    (ext_rise),
		.fall    ()
	);

	pin_edge_sync u_ch_sync
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (ch_pin_in),
		.rise    (ch_rise),
		.fall    (ch_fall)
	);

	// bus handshakes: one write and one read held at a time
	assign awready      = !s.aw_held;
	assign wready       = !s.w_held;
	assign arready      = !s.rvalid;
	assign bvalid       = s.bvalid;
	assign bresp        = s.bresp;
	assign rvalid       = s.rvalid;
	assign rdata        = s.rdata;
	assign rresp        = s.rresp;
	assign ch_pin_out   = s.pin_out;
	// capture only listens to the pin, so the driver stays off there too
	assign ch_pin_oe_n  = (s.ch.els == timer_pkg::ELS_GPIO)
		|| (mode == timer_pkg::CH_CAPTURE);
	assign overflow_irq = s.sc.flag & s.sc.ie;
	assign channel_irq  = s.ch.flag & s.ch.ie;

	always_comb
	begin
		next_s = s;
		wsc = timer_pkg::main_ctl_t'(s.wdata[7:0]);
		wch = timer_pkg::ch_ctl_t'(s.wdata[7:0]);
		// zero modulo means the full 16-bit range
		top = (s.modulo == timer_pkg::CNT_ZERO) ? timer_pkg::CNT_FREE_TOP : s.modulo;

		// prescaler input; fixed clock is taken as the bus clock here
		case (s.sc.clk_sel)
			timer_pkg::CLK_BUS,
			timer_pkg::CLK_FIXED: src = 1'b1;
			timer_pkg::CLK_EXT:   src = ext_rise;
			default:              src = 1'b0;
		endcase
		if (background_debug_mode)
			src = 1'b0; // counter frozen while debugging
		tick = src && ((s.presc & prescale_mask(s.sc.ps)) == prescale_mask(s.sc.ps));
		if (src)
			next_s.presc = s.presc + timer_pkg::PRESC_STEP;

		// counter stepping
		ovf = 1'b0;
		step_to_top = 1'b0;
		if (tick)
		begin
			step_to_top = !s.cnt_down && (s.cnt == top - timer_pkg::CNT_ONE);
			if (!s.sc.cpwm)
			begin
				if (s.cnt >= top)
				begin
					next_s.cnt = timer_pkg::CNT_ZERO;
					ovf = 1'b1;
				end
				else
					next_s.cnt = s.cnt + timer_pkg::CNT_ONE;
			end
			else if (!s.cnt_down)
			begin
				if (s.cnt >= top)
				begin
					next_s.cnt_down = 1'b1;
					next_s.cnt = s.cnt - timer_pkg::CNT_ONE;
					ovf = 1'b1;
				end
				else
					next_s.cnt = s.cnt + timer_pkg::CNT_ONE;
			end
			else if (s.cnt == timer_pkg::CNT_ZERO)
			begin
				next_s.cnt_down = 1'b0;
				next_s.cnt = s.cnt + timer_pkg::CNT_ONE;
			end
			else
				next_s.cnt = s.cnt - timer_pkg::CNT_ONE;
		end

		// channel function
		mode = channel_mode(s.sc.cpwm, s.ch.ms);
		match = tick && (next_s.cnt == s.ch_val);
		extreme = (s.ch_val == timer_pkg::CNT_ZERO) || (s.ch_val > top);
		case (mode)
			timer_pkg::CH_CAPTURE: ch_event = (ch_rise && s.ch.els[0])
				|| (ch_fall && s.ch.els[1]);
			timer_pkg::CH_COMPARE: ch_event = match;
			default:               ch_event = match && !extreme;
		endcase
		if (mode == timer_pkg::CH_CAPTURE && ch_event)
			next_s.ch_val = s.cnt;
		case (mode)
			timer_pkg::CH_COMPARE:
			begin
				if (match)
				begin
					case (s.ch.els)
						timer_pkg::ELS_TOGGLE: next_s.pin_out = !s.pin_out;
						timer_pkg::ELS_CLEAR:  next_s.pin_out = 1'b0;
						timer_pkg::ELS_SET:    next_s.pin_out = 1'b1;
						default:               next_s.pin_out = s.pin_out;
					endcase
				end
			end
			// high while below the channel value; low-true inverts
			timer_pkg::CH_EPWM,
			timer_pkg::CH_CPWM:
				next_s.pin_out = (next_s.cnt < s.ch_val) ^ s.ch.els[0];
			default:
				next_s.pin_out = s.pin_out;
		endcase

		// buffered modulo moves over once both halves are in
		if (s.lat_hi && s.lat_lo && !background_debug_mode
			&& (s.sc.clk_sel == timer_pkg::CLK_OFF || step_to_top))
		begin
			next_s.modulo = s.mod_buf;
			next_s.lat_hi = 1'b0;
			next_s.lat_lo = 1'b0;
		end

		// write channel: address and data are latched independently
		if (awvalid && !s.aw_held)
		begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && !s.w_held)
		begin
			next_s.w_held = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		do_write = s.aw_held && s.w_held && !s.bvalid;
		sc_wr = 1'b0;
		ch_wr = 1'b0;
		if (do_write)
		begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = timer_pkg::RESP_OKAY;
			case (s.aw_addr)
				timer_pkg::ADDR_MAIN_SC:
				begin
					if (s.wstrb[0])
					begin
						sc_wr = 1'b1;
						next_s.sc.ie = wsc.ie;
						next_s.sc.cpwm = wsc.cpwm;
						next_s.sc.clk_sel = wsc.clk_sel;
						next_s.sc.ps = wsc.ps;
						if (!wsc.flag && s.ovf_armed)
							next_s.sc.flag = 1'b0;
						next_s.ovf_armed = 1'b0;
						next_s.lat_hi = 1'b0;
						next_s.lat_lo = 1'b0;
					end
				end
				// any write clears the counter
				timer_pkg::ADDR_COUNT:
				begin
					next_s.cnt = timer_pkg::CNT_ZERO;
					next_s.cnt_down = 1'b0;
					next_s.presc = '0;
				end
				timer_pkg::ADDR_MOD_HI:
				begin
					if (s.wstrb[0] && background_debug_mode)
						next_s.modulo[15:8] = s.wdata[7:0];
					else if (s.wstrb[0])
					begin
						next_s.mod_buf[15:8] = s.wdata[7:0];
						next_s.lat_hi = 1'b1;
					end
				end
				timer_pkg::ADDR_MOD_LO:
				begin
					if (s.wstrb[0] && background_debug_mode)
						next_s.modulo[7:0] = s.wdata[7:0];
					else if (s.wstrb[0])
					begin
						next_s.mod_buf[7:0] = s.wdata[7:0];
						next_s.lat_lo = 1'b1;
					end
				end
				timer_pkg::ADDR_CH_SC:
				begin
					if (s.wstrb[0])
					begin
						ch_wr = 1'b1;
						next_s.ch.ie = wch.ie;
						next_s.ch.ms = wch.ms;
						next_s.ch.els = wch.els;
						// writing a one leaves the flag alone
						if (!wch.flag && s.ch_armed)
							next_s.ch.flag = 1'b0;
						next_s.ch_armed = 1'b0;
					end
				end
				// value writes are ignored while capturing
				timer_pkg::ADDR_CH_VAL:
				begin
					if (mode != timer_pkg::CH_CAPTURE && s.wstrb[0])
						next_s.ch_val[7:0] = s.wdata[7:0];
					if (mode != timer_pkg::CH_CAPTURE && s.wstrb[1])
						next_s.ch_val[15:8] = s.wdata[15:8];
				end
				default:
					next_s.bresp = timer_pkg::RESP_SLVERR;
			endcase
		end

		// read channel; status reads arm the flag clear
		ch_rd = 1'b0;
		if (arvalid && !s.rvalid)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = timer_pkg::RESP_OKAY;
			next_s.rdata = '0;
			case (araddr)
				timer_pkg::ADDR_MAIN_SC:
				begin
					next_s.rdata[7:0] = s.sc;
					if (s.sc.flag)
						next_s.ovf_armed = 1'b1;
				end
				timer_pkg::ADDR_COUNT:  next_s.rdata[15:0] = s.cnt;
				timer_pkg::ADDR_MOD_HI: next_s.rdata[7:0] = s.modulo[15:8];
				timer_pkg::ADDR_MOD_LO: next_s.rdata[7:0] = s.modulo[7:0];
				timer_pkg::ADDR_CH_SC:
				begin
					ch_rd = 1'b1;
					next_s.rdata[7:0] = {s.ch.flag, s.ch.ie, s.ch.ms, s.ch.els, 2'b00};
					if (s.ch.flag)
						next_s.ch_armed = 1'b1;
				end
				timer_pkg::ADDR_CH_VAL: next_s.rdata[15:0] = s.ch_val;
				default: next_s.rresp = timer_pkg::RESP_SLVERR;
			endcase
		end

		// hardware set wins over a clear in the same cycle
		if (ovf && !(s.lat_hi ^ s.lat_lo))
		begin
			next_s.sc.flag = 1'b1;
			next_s.ovf_armed = 1'b0;
		end
		if (ch_event)
		begin
			next_s.ch.flag = 1'b1;
			next_s.ch_armed = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= timer_pkg::STATE_RESET;
		else
			s <= next_s;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// software arms the clear by reading a set flag
	sequence arm_seq;
		ch_rd && s.ch.flag && !ch_event;
	endsequence

	// a zero write while armed, with no new event in that cycle
	sequence clear_seq;
		s.ch_armed && ch_wr && !wch.flag && !ch_event;
	endsequence

	clear_arm_a: assert property (
		arm_seq |=> s.ch_armed)
		else $error("status read of set flag did not arm clear");

	ovf_restart_a: assert property (
		tick && !s.sc.cpwm && s.cnt == top && !do_write
		|=> s.cnt == timer_pkg::CNT_ZERO
		&& (s.sc.flag || $past(s.lat_hi) != $past(s.lat_lo)))
		else $error("counter did not wrap at modulo");

	half_mod_a: assert property (
		(s.lat_hi != s.lat_lo) && !s.sc.flag |=> !s.sc.flag)
		else $error("overflow flagged during half modulo write");

	mod_direct_a: assert property (
		s.lat_hi && s.lat_lo && s.sc.clk_sel == timer_pkg::CLK_OFF
		&& !background_debug_mode && !do_write
		|=> !s.lat_hi && !s.lat_lo && s.modulo == $past(s.mod_buf))
		else $error("modulo not transferred with clock off");

	sc_reset_a: assert property (
		sc_wr |=> !s.lat_hi && !s.lat_lo)
		else $error("main control write left modulo latches");

	bdm_freeze_a: assert property (
		background_debug_mode && !sc_wr |=> $stable(s.lat_hi) && $stable(s.lat_lo))
		else $error("modulo latches moved in debug mode");

	capture_flag_a: assert property (
		mode == timer_pkg::CH_CAPTURE && ch_event |=> s.ch.flag ##1 1'b1)
		else $error("capture edge did not set flag");

	pwm_extreme_a: assert property (
		mode != timer_pkg::CH_CAPTURE && mode != timer_pkg::CH_COMPARE
		&& extreme && !s.ch.flag && !do_write |=> !s.ch.flag)
		else $error("flag set at 0 or 100 percent duty");

	ch_irq_a: assert property (
		ch_event && s.ch.ie && !ch_wr |=> channel_irq)
		else $error("channel event with enable raised no interrupt");

	flag_clear_a: assert property (
		clear_seq |=> !s.ch.flag)
		else $error("clear sequence did not clear flag");

	flag_hold_a: assert property (
		s.ch.flag && !s.ch_armed |=> s.ch.flag)
		else $error("flag cleared without armed sequence");

endmodule : timer_modulo_channel_ctrl

`default_nettype wire

// ===== verif/ch_pin_model.sv
`default_nettype none

// circuit outside the channel pin: a plain driver that the timer overrides while enabled
module ch_pin_model
(
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	input  wire logic ext_level,
	output logic      pin_level
);
	timeunit 1ns;
	timeprecision 100ps;

	// resolved wire level fed back to the timer input; timer wins while its enable is low
	always_comb
	begin
		pin_level = pin_oe_n ? ext_level : pin_out;
	end
endmodule : ch_pin_model

`default_nettype wire

// ===== verif/timer_modulo_channel_ctrl_tb.sv
`default_nettype none

// self-checking bench: register bus master, pin driver and a cycle watchdog
module timer_modulo_channel_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LIMIT = 20000;

	logic        aclk        = 1'b0;
	logic        aresetn     = 1'b0;
	logic [7:0]  awaddr      = 8'h00;
	logic        awvalid     = 1'b0;
	logic        awready;
	logic [31:0] wdata       = 32'h0;
	logic [3:0]  wstrb       = 4'hf;
	logic        wvalid      = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready      = 1'b0;
	logic [7:0]  araddr      = 8'h00;
	logic        arvalid     = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready      = 1'b0;
	logic        dbg         = 1'b0;
	logic        ext_clk     = 1'b0;
	logic        ext_level   = 1'b0;
	logic        ch_pin_in;
	logic        ch_pin_out;
	logic        ch_pin_oe_n;
	logic        overflow_irq;
	logic        channel_irq;
	logic [31:0] last_data;
	logic [1:0]  last_resp;
	int          n_mismatch  = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	timer_modulo_channel_ctrl uut
	(
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .background_debug_mode(dbg), .ext_clk_pin(ext_clk), .ch_pin_in,
		.ch_pin_out, .ch_pin_oe_n, .overflow_irq, .channel_irq
	);

	ch_pin_model far_side
	(
		.pin_out(ch_pin_out), .pin_oe_n(ch_pin_oe_n), .ext_level, .pin_level(ch_pin_in)
	);

	always #10 aclk = ~aclk;

	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// a hang counts as a mismatch and ends the run
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_mismatch++;
			test_done();
		end
	end

	// case equality so an unknown never passes
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ready is sampled mid-cycle, so each channel drops its valid at the edge it is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic pa;
		logic pw;
		logic ta;
		logic tw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw)
		begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			@(posedge aclk);
			pa = pa && !ta;
			pw = pw && !tw;
			awvalid <= pa;
			wvalid <= pw;
		end
		ta = 1'b0;
		while (!ta)
		begin
			@(negedge aclk);
			ta = bvalid;
			last_resp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic p;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		p = 1'b0;
		while (!p)
		begin
			@(negedge aclk);
			p = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		p = 1'b0;
		while (!p)
		begin
			@(negedge aclk);
			p = rvalid;
			last_data = rdata;
			last_resp = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(last_data, exp);
	endtask : rdc

	// leaves early once the chosen interrupt is seen high (0 overflow, 1 channel)
	task automatic wait_hi(input logic sel_ch, input int n, output logic seen);
		seen = 1'b0;
		for (int k = 0; k < n && !seen; k++)
		begin
			@(negedge aclk);
			seen = ((sel_ch ? channel_irq : overflow_irq) === 1'b1);
		end
	endtask : wait_hi

	task automatic t_reset();
		rdc(timer_pkg::ADDR_MAIN_SC, 32'h0);
		rdc(timer_pkg::ADDR_MOD_HI, 32'h0);
		rdc(timer_pkg::ADDR_MOD_LO, 32'h0);
		rdc(timer_pkg::ADDR_CH_SC, 32'h0);
		rdc(timer_pkg::ADDR_COUNT, 32'h0);
		chk(ch_pin_oe_n, 1'b1);
		rdc(8'h3c, 32'h0);
		chk(last_resp, timer_pkg::RESP_SLVERR);
		wr(8'h3c, 32'hff);
		chk(last_resp, timer_pkg::RESP_SLVERR);
	endtask : t_reset

	// counter stopped: pair transfer, latch reset by main control, debug bypass
	task automatic t_modulo();
		wr(timer_pkg::ADDR_MOD_HI, 32'h12);
		rdc(timer_pkg::ADDR_MOD_HI, 32'h0);
		wr(timer_pkg::ADDR_MOD_LO, 32'h34);
		rdc(timer_pkg::ADDR_MOD_HI, 32'h12);
		rdc(timer_pkg::ADDR_MOD_LO, 32'h34);
		wr(timer_pkg::ADDR_MOD_HI, 32'h55);
		wr(timer_pkg::ADDR_MAIN_SC, 32'h0);
		wr(timer_pkg::ADDR_MOD_LO, 32'h66);
		rdc(timer_pkg::ADDR_MOD_LO, 32'h34);
		wr(timer_pkg::ADDR_MAIN_SC, 32'h0);
		wr(timer_pkg::ADDR_MOD_HI, 32'h00);
		dbg <= 1'b1;
		wr(timer_pkg::ADDR_MOD_LO, 32'h40);
		rdc(timer_pkg::ADDR_MOD_LO, 32'h40);
		rdc(timer_pkg::ADDR_MOD_HI, 32'h12);
		dbg <= 1'b0;
		wr(timer_pkg::ADDR_MOD_LO, 32'h40);
		rdc(timer_pkg::ADDR_MOD_HI, 32'h0);
	endtask : t_modulo

	// modulo 0x40 running: wrap, clear, inhibit while half written, then 0x30 at top
	task automatic t_overflow();
		logic s;
		wr(timer_pkg::ADDR_COUNT, 32'h0);
		wr(timer_pkg::ADDR_MAIN_SC, 32'h48);
		wait_hi(1'b0, 100, s);
		chk(s, 1'b1);
		rdc(timer_pkg::ADDR_MAIN_SC, 32'hc8);
		wr(timer_pkg::ADDR_MAIN_SC, 32'h48);
		chk(overflow_irq, 1'b0);
		wr(timer_pkg::ADDR_MOD_HI, 32'h0);
		wait_hi(1'b0, 200, s);
		chk(s, 1'b0);
		wr(timer_pkg::ADDR_COUNT, 32'h0);
		wr(timer_pkg::ADDR_MOD_LO, 32'h30);
		rdc(timer_pkg::ADDR_MOD_LO, 32'h40);
		wait_hi(1'b0, 200, s);
		chk(s, 1'b1);
		rdc(timer_pkg::ADDR_MOD_LO, 32'h30);
		wr(timer_pkg::ADDR_MAIN_SC, 32'h08);
	endtask : t_overflow

	task automatic t_compare();
		logic s;
		// value writes are ignored in capture mode, so leave capture first
		wr(timer_pkg::ADDR_CH_SC, 32'h54);
		wr(timer_pkg::ADDR_CH_VAL, 32'h10);
		wait_hi(1'b1, 70, s);
		chk(s, 1'b1);
		chk(ch_pin_oe_n, 1'b0);
		rdc(timer_pkg::ADDR_CH_SC, 32'hd4);
		wr(timer_pkg::ADDR_CH_SC, 32'h54);
		chk(channel_irq, 1'b0);
		wr(timer_pkg::ADDR_CH_SC, 32'hd4);
		chk(channel_irq, 1'b0);
		wait_hi(1'b1, 70, s);
		rd(timer_pkg::ADDR_CH_SC);
		repeat (70) @(posedge aclk);
		wr(timer_pkg::ADDR_CH_SC, 32'h54);
		chk(channel_irq, 1'b1);
		for (int e = 2; e < 4; e++)
		begin
			wr(timer_pkg::ADDR_CH_SC, 32'h50 | (e << 2));
			repeat (70) @(posedge aclk);
			chk(ch_pin_out, e[0]);
		end
	endtask : t_compare

	// edge selects 1 to 3: rising then falling edge on the pin
	task automatic t_capture();
		wr(timer_pkg::ADDR_CH_SC, 32'h00);
		chk(ch_pin_oe_n, 1'b1);
		rd(timer_pkg::ADDR_CH_SC);
		wr(timer_pkg::ADDR_CH_SC, 32'h00);
		for (int e = 1; e < 4; e++)
		begin
			ext_level <= 1'b0;
			repeat (4) @(posedge aclk);
			wr(timer_pkg::ADDR_CH_SC, e << 2);
			rdc(timer_pkg::ADDR_CH_SC, e << 2);
			chk(ch_pin_oe_n, 1'b1);
			ext_level <= 1'b1;
			repeat (8) @(posedge aclk);
			rdc(timer_pkg::ADDR_CH_SC, (e << 2) | (e[0] << 7));
			wr(timer_pkg::ADDR_CH_SC, e << 2);
			ext_level <= 1'b0;
			repeat (8) @(posedge aclk);
			rdc(timer_pkg::ADDR_CH_SC, (e << 2) | (e[1] << 7));
			wr(timer_pkg::ADDR_CH_SC, e << 2);
		end
	endtask : t_capture

	// pwm extremes never flag; center-aligned still flags on match
	task automatic t_pwm();
		logic s;
		wr(timer_pkg::ADDR_CH_SC, 32'h28);
		wr(timer_pkg::ADDR_CH_VAL, 32'h0);
		rd(timer_pkg::ADDR_CH_SC);
		wr(timer_pkg::ADDR_CH_SC, 32'h28);
		repeat (140) @(posedge aclk);
		rdc(timer_pkg::ADDR_CH_SC, 32'h28);
		chk(ch_pin_out, 1'b0);
		wr(timer_pkg::ADDR_CH_VAL, 32'h41);
		repeat (140) @(posedge aclk);
		rdc(timer_pkg::ADDR_CH_SC, 32'h28);
		chk(ch_pin_out, 1'b1);
		wr(timer_pkg::ADDR_CH_SC, 32'h24);
		repeat (4) @(posedge aclk);
		chk(ch_pin_out, 1'b0);
		wr(timer_pkg::ADDR_CH_VAL, 32'h10);
		// counter stopped while the old flag is cleared, so no match can slip in
		wr(timer_pkg::ADDR_MAIN_SC, 32'h20);
		rd(timer_pkg::ADDR_CH_SC);
		wr(timer_pkg::ADDR_CH_SC, 32'h68);
		chk(channel_irq, 1'b0);
		wr(timer_pkg::ADDR_MAIN_SC, 32'h28);
		wait_hi(1'b1, 300, s);
		chk(s, 1'b1);
	endtask : t_pwm

	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_modulo();
		t_overflow();
		t_compare();
		t_capture();
		t_pwm();
		test_done();
	end
endmodule : timer_modulo_channel_ctrl_tb

`default_nettype wire
